// >>> rtl/udl_consts.svh
/*
 * Offsets, field positions, reset values and fixed codes of the descriptor lookup.
 * Assumes a 2KB byte-wide serial memory behind a simple byte access port.
 */
`ifndef UDL_CONSTS_SVH
`define UDL_CONSTS_SVH
// Memory layout.
`define UDL_LEN_ADDR    11'h000
`define UDL_LANG_ADDR   11'h002
`define UDL_PTR_ADDR    11'h010
`define UDL_DEV_IDENT   8'h40
`define UDL_CFG_CODE    6'h08
`define UDL_STR_FLAG    1'b1
`define UDL_ERASED      8'hff
`define UDL_ALIGN       3'h0
`define UDL_LEN_MIN     8'h04
`define UDL_LEN_MAX     8'h10
`define UDL_LANG_FIRST  3'h1
`define UDL_LANG_LAST   3'h7
`define UDL_STR_ZERO    4'h0
`define UDL_PTR_ENTRIES 32
// Register map, byte offsets.
`define UDL_R_EE_CTRL   8'h00
`define UDL_R_EE_ADDR   8'h04
`define UDL_R_EE_WDATA  8'h08
`define UDL_R_EE_RDATA  8'h0c
`define UDL_R_LK_CTRL   8'h10
`define UDL_R_LK_STAT   8'h14
// Register fields.
`define UDL_GO_BIT      0
`define UDL_DIR_BIT     1
`define UDL_BUSY_BIT    2
`define UDL_EN_BIT      0
`define UDL_FOUND_BIT   1
`define UDL_LKADDR_LSB  16
`define UDL_LKEN_RST    1'b0
`endif

// >>> rtl/udl_pkg.sv
/*
 * Types shared by the descriptor lookup modules.
 * Assumes nothing beyond the constants header.
 */
package udl_pkg;
    typedef enum logic [1:0] {K_DEV = 2'h0, K_CFG = 2'h1, K_STR = 2'h2} udl_kind_t;
    typedef struct packed {
        udl_kind_t   kind;
        logic [3:0]  index;
        logic [15:0] langid;
    } udl_desc_req_t;
    typedef struct packed {
        logic        we;
        logic [10:0] addr;
        logic [7:0]  wdata;
    } udl_ee_cmd_t;
    typedef enum logic [5:0] {
        S_IDLE = 6'b000001,
        S_LEN  = 6'b000010,
        S_LLO  = 6'b000100,
        S_LHI  = 6'b001000,
        S_ID   = 6'b010000,
        S_PTR  = 6'b100000
    } udl_state_t;
endpackage : udl_pkg

// >>> rtl/udl_ee_port.sv
/*
 * Single-access arbiter in front of the serial memory byte port.
 * Assumes the memory side answers each held request with a one-cycle ack.
 */
`include "udl_consts.svh"
module udl_ee_port
    import udl_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Host byte access
    input  wire logic        host_go,
    input  wire udl_ee_cmd_t host_cmd,
    output logic [7:0]       host_rdata,
    // Lookup fetch
    input  wire logic        fetch_req,
    input  wire logic [10:0] fetch_addr,
    output logic             fetch_done,
    output logic [7:0]       fetch_rdata,
    // Memory byte port
    output logic             ee_req,
    output udl_ee_cmd_t      ee_cmd,
    input  wire logic        ee_ack,
    input  wire logic [7:0]  ee_rdata
);
    logic host_act_r;

    // Host wins a tie; a go that arrives while busy is dropped.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ee_req      <= 1'b0;
            ee_cmd      <= '0;
            host_act_r  <= 1'b0;
            fetch_done  <= 1'b0;
            fetch_rdata <= '0;
            host_rdata  <= '0;
        end else begin
            fetch_done <= 1'b0;
            if (!ee_req) begin
                if (host_go) begin
                    ee_req     <= 1'b1;
                    ee_cmd     <= host_cmd;
                    host_act_r <= 1'b1;
                end else if (fetch_req && !fetch_done) begin
                    ee_req     <= 1'b1;
                    ee_cmd     <= '{we: 1'b0, addr: fetch_addr, wdata: 8'h00};
                    host_act_r <= 1'b0;
                end
            end else if (ee_ack) begin
                ee_req <= 1'b0;
                if (host_act_r) begin
                    host_rdata <= ee_rdata;
                end else begin
                    fetch_rdata <= ee_rdata;
                    fetch_done  <= 1'b1;
                end
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    fetch_read_a: assert property (ee_req && !host_act_r |-> !ee_cmd.we)
        else $error("lookup fetch issued a write");
    host_excl_a: assert property (ee_req && host_act_r |=> !fetch_done)
        else $error("fetch completed during host access");
    host_cov_c: cover property (ee_req && host_act_r && ee_cmd.we ##[1:40] ee_ack);
endmodule : udl_ee_port

// >>> rtl/udl_ahb_slave.sv
/*
 * AHB-Lite register slave of the descriptor lookup, zero wait states.
 * Assumes a single master; only the low eight address bits are decoded.
 */
`include "udl_consts.svh"
module udl_ahb_slave
    import udl_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Block side
    output logic             host_go,
    output udl_ee_cmd_t      host_cmd,
    output logic             lookup_en,
    input  wire logic        ee_busy,
    input  wire logic [7:0]  host_rdata,
    input  wire logic        lk_busy,
    input  wire logic        lk_found,
    input  wire logic [10:0] lk_addr
);
    logic       wr_pend_r;
    logic [7:0] wa_r;
    logic       acc;

    assign acc = hsel && hready && htrans[1];

    // Read data is latched in the address phase so no wait state is needed.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend_r <= 1'b0;
            wa_r      <= '0;
        end else begin
            wr_pend_r <= acc && hwrite;
            wa_r      <= haddr[7:0];
            hrdata    <= '0;
            if (acc && !hwrite) begin
                case (haddr[7:0])
                    // pending go is busy
                    // A go pulse counts as busy so that a poll straight after
                    // the control write never sees a stale idle.
                    `UDL_R_EE_CTRL:  hrdata[`UDL_BUSY_BIT:`UDL_DIR_BIT] <=
                                         {ee_busy || host_go, host_cmd.we};
                    `UDL_R_EE_ADDR:  hrdata[10:0] <= host_cmd.addr;
                    `UDL_R_EE_WDATA: hrdata[7:0] <= host_cmd.wdata;
                    `UDL_R_EE_RDATA: hrdata[7:0] <= host_rdata;
                    `UDL_R_LK_CTRL:  hrdata[`UDL_EN_BIT] <= lookup_en;
                    `UDL_R_LK_STAT:  hrdata <= {5'h00, lk_addr, 14'h0000, lk_found, lk_busy};
                    default:         hrdata <= '0;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            host_go   <= 1'b0;
            host_cmd  <= '0;
            lookup_en <= `UDL_LKEN_RST;
        end else begin
            host_go <= 1'b0;
            if (wr_pend_r) begin
                case (wa_r)
                    `UDL_R_EE_CTRL: begin
                        host_go     <= hwdata[`UDL_GO_BIT];
                        host_cmd.we <= hwdata[`UDL_DIR_BIT];
                    end
                    `UDL_R_EE_ADDR:  host_cmd.addr  <= hwdata[10:0];
                    `UDL_R_EE_WDATA: host_cmd.wdata <= hwdata[7:0];
                    `UDL_R_LK_CTRL:  lookup_en      <= hwdata[`UDL_EN_BIT];
                    default:         host_go        <= 1'b0;
                endcase
            end
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    host_go_a: assert property (wr_pend_r && wa_r == `UDL_R_EE_CTRL && hwdata[0] |=> host_go)
        else $error("control write did not start a host access");
endmodule : udl_ahb_slave

// >>> rtl/udl_top.sv
/*
 * Descriptor lookup: walks the language table and the pointer table held in an
 * optional 2KB serial memory and returns the start address of a descriptor.
 * Assumes the memory wire protocol is handled outside a simple byte port, and
 * that one descriptor request is made at a time.
 */
//
// Contract
// - Works without memory; lookup optional
// - Normal operation only reads the memory
// - Registers give host single byte access
// - One device, four configs, fifteen strings, seven languages
// - String zero returns language table
// - Language identifiers paired low byte first
// - First language is the fallback
// - Pointer table locates each descriptor
// - Entry is identifier then upper address
// - Pointers count eight byte steps
// - Location 011 points to device descriptor; code scans the table for identifier 40 instead
// - Configuration identifiers carry code 001000
// - Configuration index in bits one to zero
// - String identifier: flag, language, index
`include "udl_consts.svh"
module udl_top
    import udl_pkg::*;
#(
    parameter int MAX_ENTRIES = `UDL_PTR_ENTRIES
)
(
    // Clock and reset
    input  wire logic          hclk,
    input  wire logic          hresetn,
    // AHB-Lite slave
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic          hready,
    input  wire logic [31:0]   hwdata,
    output logic [31:0]        hrdata,
    output logic               hreadyout,
    output logic               hresp,
    // Descriptor responder
    input  wire logic          desc_req,
    input  wire udl_desc_req_t desc_cmd,
    output logic               desc_done,
    output logic               desc_found,
    output logic [10:0]        desc_addr,
    // Serial memory byte port
    output logic               ee_req,
    output udl_ee_cmd_t        ee_cmd,
    input  wire logic          ee_ack,
    input  wire logic [7:0]    ee_rdata
);
    // ----------------------------------------------------------------
    // Local signals
    // ----------------------------------------------------------------
    udl_state_t    state_r;
    udl_desc_req_t req_r;
    logic          fetch_req_r;
    logic [10:0]   fetch_addr_r;
    logic          fetch_done;
    logic [7:0]    fetch_rdata;
    logic [7:0]    ident_r;
    logic [2:0]    lang_cnt_r;
    logic [2:0]    lang_num_r;
    logic [7:0]    lang_lo_r;
    logic [5:0]    entry_r;
    logic          host_go;
    udl_ee_cmd_t   host_cmd;
    logic [7:0]    host_rdata;
    logic          lookup_en;
    logic          lang_hit;
    logic          last_entry;

    function automatic logic [2:0] lang_count(input logic [7:0] len);
        logic [6:0] half;
        half = len[7:1] - 7'h01;
        if (len < `UDL_LEN_MIN) begin
            return `UDL_LANG_FIRST;
        end
        if (len > `UDL_LEN_MAX) begin
            return `UDL_LANG_LAST;
        end
        return half[2:0];
    endfunction : lang_count

    assign lang_hit   = ({fetch_rdata, lang_lo_r} == req_r.langid) &&
                        ({fetch_rdata, lang_lo_r} != {`UDL_ERASED, `UDL_ERASED});
    assign last_entry = (entry_r == 6'(MAX_ENTRIES - 1));

    // ----------------------------------------------------------------
    // Submodules
    // ----------------------------------------------------------------
    udl_ahb_slave u_slave (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .hsel       (hsel),
        .haddr      (haddr),
        .htrans     (htrans),
        .hwrite     (hwrite),
        .hready     (hready),
        .hwdata     (hwdata),
        .hrdata     (hrdata),
        .hreadyout  (hreadyout),
        .hresp      (hresp),
        .host_go    (host_go),
        .host_cmd   (host_cmd),
        .lookup_en  (lookup_en),
        .ee_busy    (ee_req),
        .host_rdata (host_rdata),
        .lk_busy    (state_r != S_IDLE),
        .lk_found   (desc_found),
        .lk_addr    (desc_addr)
    );

    udl_ee_port u_port (
        .clk         (hclk),
        .rst_n       (hresetn),
        .host_go     (host_go),
        .host_cmd    (host_cmd),
        .host_rdata  (host_rdata),
        .fetch_req   (fetch_req_r),
        .fetch_addr  (fetch_addr_r),
        .fetch_done  (fetch_done),
        .fetch_rdata (fetch_rdata),
        .ee_req      (ee_req),
        .ee_cmd      (ee_cmd),
        .ee_ack      (ee_ack),
        .ee_rdata    (ee_rdata)
    );

    // ----------------------------------------------------------------
    // Lookup sequencer
    // ----------------------------------------------------------------
    // Requests that arrive while a lookup runs are ignored; the responder
    // must wait for desc_done. The fetch request stays high across states
    // and the port guards against reissuing on the done cycle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r      <= S_IDLE;
            req_r        <= '0;
            fetch_req_r  <= 1'b0;
            fetch_addr_r <= '0;
            ident_r      <= '0;
            lang_cnt_r   <= `UDL_LANG_FIRST;
            lang_num_r   <= `UDL_LANG_FIRST;
            lang_lo_r    <= '0;
            entry_r      <= '0;
            desc_done    <= 1'b0;
            desc_found   <= 1'b0;
            desc_addr    <= '0;
        end else begin
            desc_done <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    if (desc_req) begin
                        req_r <= desc_cmd;
                        if (!lookup_en) begin
                            desc_done  <= 1'b1;
                            desc_found <= 1'b0;
                        end else if (desc_cmd.kind == K_STR &&
                                     desc_cmd.index == `UDL_STR_ZERO) begin
                            desc_done  <= 1'b1;
                            desc_found <= 1'b1;
                            desc_addr  <= `UDL_LEN_ADDR;
                        end else if (desc_cmd.kind == K_STR) begin
                            state_r      <= S_LEN;
                            fetch_req_r  <= 1'b1;
                            fetch_addr_r <= `UDL_LEN_ADDR;
                        end else begin
                            ident_r <= (desc_cmd.kind == K_DEV) ? `UDL_DEV_IDENT :
                                       {`UDL_CFG_CODE, desc_cmd.index[1:0]};
                            state_r      <= S_ID;
                            fetch_req_r  <= 1'b1;
                            fetch_addr_r <= `UDL_PTR_ADDR;
                            entry_r      <= '0;
                        end
                    end
                end
                S_LEN: begin
                    if (fetch_done) begin
                        lang_cnt_r   <= lang_count(fetch_rdata);
                        lang_num_r   <= `UDL_LANG_FIRST;
                        fetch_addr_r <= `UDL_LANG_ADDR;
                        state_r      <= S_LLO;
                    end
                end
                S_LLO: begin
                    if (fetch_done) begin
                        lang_lo_r    <= fetch_rdata;
                        fetch_addr_r <= fetch_addr_r + 11'h001;
                        state_r      <= S_LHI;
                    end
                end
                S_LHI: begin
                    if (fetch_done) begin
                        if (lang_hit || lang_num_r == lang_cnt_r) begin
                            ident_r <= {`UDL_STR_FLAG,
                                        lang_hit ? lang_num_r : `UDL_LANG_FIRST,
                                        req_r.index};
                            fetch_addr_r <= `UDL_PTR_ADDR;
                            entry_r      <= '0;
                            state_r      <= S_ID;
                        end else begin
                            lang_num_r   <= lang_num_r + 3'h1;
                            fetch_addr_r <= fetch_addr_r + 11'h001;
                            state_r      <= S_LLO;
                        end
                    end
                end
                S_ID: begin
                    if (fetch_done) begin
                        if (fetch_rdata == ident_r) begin
                            fetch_addr_r <= fetch_addr_r + 11'h001;
                            state_r      <= S_PTR;
                        end else if (fetch_rdata == `UDL_ERASED || last_entry) begin
                            desc_done   <= 1'b1;
                            desc_found  <= 1'b0;
                            fetch_req_r <= 1'b0;
                            state_r     <= S_IDLE;
                        end else begin
                            fetch_addr_r <= fetch_addr_r + 11'h002;
                            entry_r      <= entry_r + 6'h01;
                        end
                    end
                end
                S_PTR: begin
                    if (fetch_done) begin
                        desc_addr   <= {fetch_rdata, `UDL_ALIGN};
                        desc_done   <= 1'b1;
                        desc_found  <= 1'b1;
                        fetch_req_r <= 1'b0;
                        state_r     <= S_IDLE;
                    end
                end
                default: begin
                    fetch_req_r <= 1'b0;
                    state_r     <= S_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    done_pulse_a: assert property (desc_done |=> !desc_done)
        else $error("desc_done longer than one cycle");
    addr_align_a: assert property (desc_done && desc_found |-> desc_addr[2:0] == 3'h0)
        else $error("descriptor address not eight byte aligned");
    no_memory_a: assert property (state_r == S_IDLE && desc_req && !lookup_en
        |=> desc_done && !desc_found)
        else $error("lookup disabled but descriptor reported");
    lang_table_a: assert property (state_r == S_IDLE && desc_req && lookup_en &&
        desc_cmd.kind == K_STR && desc_cmd.index == 4'h0
        |=> desc_done && desc_found && desc_addr == 11'h000)
        else $error("string zero did not return language table");
    lang_fallback_a: assert property (state_r == S_LHI && fetch_done && !lang_hit &&
        lang_num_r == lang_cnt_r |=> ident_r[6:4] == 3'h1)
        else $error("unknown language not mapped to first");
    ptr_start_a: assert property ($rose(state_r == S_ID)
        |-> fetch_addr_r == 11'h010 && fetch_req_r)
        else $error("pointer scan did not start at table");
    ptr_byte_a: assert property (state_r == S_PTR |-> fetch_addr_r[0])
        else $error("pointer byte fetched from even address");
    scan_step_a: assert property (state_r == S_ID && fetch_done && fetch_rdata != ident_r &&
        fetch_rdata != 8'hff && !last_entry
        |=> state_r == S_ID && fetch_addr_r == $past(fetch_addr_r) + 11'h002)
        else $error("pointer scan did not step by two");
    cfg_ident_a: assert property (state_r == S_ID && req_r.kind == K_CFG
        |-> ident_r == {6'h08, req_r.index[1:0]})
        else $error("configuration identifier malformed");
    str_ident_a: assert property (state_r == S_ID && req_r.kind == K_STR
        |-> ident_r[7] && ident_r[3:0] == req_r.index)
        else $error("string identifier malformed");
    lang_limit_a: assert property (state_r == S_LLO
        |-> lang_num_r <= lang_cnt_r && lang_cnt_r <= 3'h7)
        else $error("language scan beyond table");
    dev_ident_a: assert property (state_r == S_PTR && req_r.kind == K_DEV
        |-> ident_r == 8'h40)
        else $error("device pointer taken for wrong identifier");

    str_found_c: cover property (state_r == S_LHI ##[1:200] desc_done && desc_found);
    dev_found_c: cover property (req_r.kind == K_DEV && desc_done && desc_found);
    absent_c:    cover property (state_r == S_ID && desc_done && !desc_found);
    fallback_c:  cover property (state_r == S_LHI && fetch_done && !lang_hit &&
                                 lang_num_r == lang_cnt_r);
endmodule : udl_top

// >>> verification/udl_ee_model.sv
/* Behavioural 2KB serial memory behind the byte port of the lookup.
   Assumes a request held until its one-cycle ack; dly sets the wait. */
module udl_ee_model
    import udl_pkg::*;
(
    // Byte port
    input  wire logic        clk,
    input  wire logic [1:0]  dly,
    input  wire logic        ee_req,
    input  wire udl_ee_cmd_t ee_cmd,
    output logic             ee_ack,
    output logic [7:0]       ee_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [2048];
    logic [1:0] cnt = 2'h0;
    initial begin
        foreach (mem[i]) mem[i] = 8'hff;
        {mem[0], mem[1], mem[2], mem[3], mem[4], mem[5]} = 48'h06_03_09_04_07_04;
        {mem[16], mem[17], mem[18], mem[19], mem[20], mem[21]} = 48'h40_05_20_06_21_07;
        {mem[22], mem[23], mem[24], mem[25]} = 32'h90_00_a0_00;
        {mem[26], mem[27], mem[28], mem[29]} = 32'h91_08_a1_09;
        ee_ack = 1'b0;
        ee_rdata = 8'h00;
    end
    // Outside an ack the data line toggles, so stale data never matches.
    always @(posedge clk) begin
        ee_ack <= 1'b0;
        if (ee_req && !ee_ack && cnt == dly) begin
            ee_ack <= 1'b1;
            cnt <= 2'h0;
            ee_rdata <= mem[ee_cmd.addr];
            if (ee_cmd.we) mem[ee_cmd.addr] <= ee_cmd.wdata;
        end else begin
            if (ee_req && !ee_ack) cnt <= cnt + 2'h1;
            ee_rdata <= ~ee_rdata;
        end
    end
endmodule : udl_ee_model

// >>> verification/usb_descriptor_eeprom_lookup_tb.sv
/* Self-checking bench: register tasks over AHB-Lite, descriptor lookups.
   Assumes the memory model above and a zero-wait register slave. */
`include "udl_consts.svh"
module usb_descriptor_eeprom_lookup_tb
    import udl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, ee_req, ee_ack;
    logic desc_req, desc_done, desc_found;
    logic [31:0] haddr, hwdata, hrdata, d;
    logic [1:0] htrans, dly;
    logic [2:0] hsize;
    logic [10:0] desc_addr;
    logic [7:0] ee_rdata;
    udl_desc_req_t desc_cmd;
    udl_ee_cmd_t ee_cmd;
    int fail_count = 0, cmp_count = 0, wcnt = 0;
    assign hready = hreadyout;
    udl_top #(.MAX_ENTRIES(8)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .desc_req(desc_req), .desc_cmd(desc_cmd), .desc_done(desc_done),
        .desc_found(desc_found), .desc_addr(desc_addr), .ee_req(ee_req),
        .ee_cmd(ee_cmd), .ee_ack(ee_ack), .ee_rdata(ee_rdata));
    udl_ee_model mem_u (.clk(hclk), .dly(dly), .ee_req(ee_req), .ee_cmd(ee_cmd),
        .ee_ack(ee_ack), .ee_rdata(ee_rdata));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    always @(posedge hclk) if (ee_ack && ee_cmd.we) wcnt++;
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            $display("[FAIL] %s expected %h seen %h", n, e, s);
            fail_count++;
        end
    endtask : chk
    task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        d = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : bus
    task host(input logic [31:0] c);
        bus(1'b1, `UDL_R_EE_CTRL, c);
        bus(1'b0, `UDL_R_EE_CTRL, 32'h0);
        chk("ee_ctrl busy", {29'h0, 1'b1, c[1], 1'b0}, d);
        for (int i = 0; i < 40 && d[`UDL_BUSY_BIT] !== 1'b0; i++) begin
            bus(1'b0, `UDL_R_EE_CTRL, 32'h0);
        end
        chk("ee_ctrl idle", {30'h0, c[1], 1'b0}, d);
    endtask : host
    task look(input udl_kind_t k, input logic [3:0] x, input logic [15:0] l,
              input logic f, input logic [10:0] a);
        int n;
        desc_req <= 1'b1;
        desc_cmd <= '{k, x, l};
        @(posedge hclk);
        desc_req <= 1'b0;
        n = 0;
        do begin @(posedge hclk); n++; end while (desc_done !== 1'b1 && n < 300);
        chk("desc_done", 32'h1, {31'h0, desc_done});
        chk("desc_found", {31'h0, f}, {31'h0, desc_found});
        chk("desc_addr", {21'h0, a}, {21'h0, desc_addr});
    endtask : look
    task final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    initial begin
        #100000;
        fail_count++;
        final_report;
    end
    initial begin
        {hresetn, hsel, hwrite, desc_req, haddr, hwdata, htrans, dly} = '0;
        hsize = 3'h2;
        desc_cmd = '0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, `UDL_R_LK_CTRL, 32'h0);
        chk("lk_ctrl reset", 32'h0, d);
        look(K_DEV, 4'h0, 16'h0, 1'b0, 11'h0);
        $display("test disabled done");
        bus(1'b1, `UDL_R_LK_CTRL, 32'h1);
        look(K_DEV, 4'h0, 16'h0, 1'b1, 11'h028);
        bus(1'b0, `UDL_R_LK_STAT, 32'h0);
        chk("lk_stat", {5'h0, 11'h028, 14'h0, 2'h2}, d);
        dly <= 2'h3;
        look(K_CFG, 4'h0, 16'h0, 1'b1, 11'h030);
        look(K_CFG, 4'h1, 16'h0, 1'b1, 11'h038);
        look(K_CFG, 4'h3, 16'h0, 1'b0, 11'h038);
        look(K_STR, 4'h1, 16'h0407, 1'b1, 11'h048);
        dly <= 2'h0;
        look(K_STR, 4'h1, 16'h1234, 1'b1, 11'h040);
        look(K_STR, 4'h0, 16'h0407, 1'b1, 11'h000);
        $display("test lookup done");
        bus(1'b1, `UDL_R_EE_ADDR, 32'h7f8);
        bus(1'b1, `UDL_R_EE_WDATA, 32'h5a);
        host(32'h3);
        bus(1'b1, `UDL_R_EE_WDATA, 32'h0);
        host(32'h1);
        bus(1'b0, `UDL_R_EE_RDATA, 32'h0);
        chk("ee_rdata written", 32'h5a, d);
        bus(1'b1, `UDL_R_EE_ADDR, 32'h011);
        host(32'h1);
        bus(1'b0, `UDL_R_EE_RDATA, 32'h0);
        chk("ee_rdata image", 32'h05, d);
        chk("memory writes", 32'h1, wcnt);
        $display("test host access done");
        bus(1'b0, 8'h18, 32'h0);
        chk("unmapped", 32'h0, d);
        $display("test unmapped done");
        final_report;
    end
endmodule : usb_descriptor_eeprom_lookup_tb
